/* File: design/tsl_pkg.sv */
// Constants shared by the touch sensor serial link block.
// Assumes a 25 MHz system clock; link pins arrive asynchronously.
`default_nettype none
package tsl_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 25000000;
    localparam int unsigned SCK_MAX_HZ = 1500000;
    localparam int unsigned SCK_PHASE_MIN_NS = 333;
    localparam int unsigned SS_LEAD_MIN_NS = 1000;
    localparam int unsigned GAP_NORMAL_US = 150;
    localparam int unsigned GAP_FAST_US = 50;
    localparam int unsigned WAKE_GAP_US = 150;
    localparam int unsigned RESET_WAIT_MS = 160;
    localparam int unsigned STORE_WAIT_MS = 200;
    localparam int unsigned RESTORE_WAIT_MS = 150;
    localparam int unsigned ERASE_WAIT_MS = 50;
    localparam int unsigned OSC_HZ = 8000000;
    // Least times round up to whole cycles
    localparam int unsigned SS_LEAD_CYC = (SS_LEAD_MIN_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned GAP_NORMAL_CYC = GAP_NORMAL_US * (SYS_CLK_HZ / 1000000);
    localparam int unsigned GAP_FAST_CYC = GAP_FAST_US * (SYS_CLK_HZ / 1000000);
    localparam int unsigned WAKE_GAP_CYC = WAKE_GAP_US * (SYS_CLK_HZ / 1000000);
    localparam int unsigned RESET_WAIT_CYC = RESET_WAIT_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned STORE_WAIT_CYC = STORE_WAIT_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned RESTORE_WAIT_CYC = RESTORE_WAIT_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned ERASE_WAIT_CYC = ERASE_WAIT_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned BUSY_W = 23;
    // ------------------------------------------------------------
    // Wait kinds requested by the command logic
    // ------------------------------------------------------------
    localparam logic [2:0] WAIT_NONE = 3'h0;
    localparam logic [2:0] WAIT_RESET = 3'h1;
    localparam logic [2:0] WAIT_STORE = 3'h2;
    localparam logic [2:0] WAIT_RESTORE = 3'h3;
    localparam logic [2:0] WAIT_ERASE = 3'h4;
    localparam logic [2:0] WAIT_TO_NORMAL = 3'h5;
    localparam logic [7:0] RESET_BYTE = 8'hff;
    localparam logic [1:0] STATE_W_UNUSED = 2'h0;
    typedef enum logic [2:0] {
        TSL_IDLE = 3'b001,
        TSL_SHIFT = 3'b010,
        TSL_GAP = 3'b100
    } tsl_state_t;
endpackage
`default_nettype wire

/* File: design/tsl_busy_timer.sv */
// Down counter that holds the link busy after a byte or slow command.
// Assumes the load pulse comes from logic on the same clock.
`default_nettype none
module tsl_busy_timer #(
    parameter int unsigned W = 23
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic busy_o
);
    // Elaboration refuses widths the counter cannot serve
    if (W < 2 || W > 31) begin
        $error("tsl_busy_timer: bad width");
    end
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic busy_q;
    logic busy_d;
    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
        busy_d = (cnt_d != '0);
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end
    assign busy_o = busy_q;
endmodule
`default_nettype wire

/* File: design/tsl_link.sv */
// Serial slave link of a touch sensor, as seen inside the sensor.
// Assumes link pins are asynchronous and sampled by sys_clk_i.
// Contract
// - The clock idles high and each side presents its next bit on the falling edge.
// - Each side captures its input bit on the rising edge that ends the period.
// - A sleeping device wakes on select or change-notify low, then the host waits 150 us.
// - Logic is timed from an 8 MHz oscillator with spread spectrum only during bursts; this block counts 25 MHz sys_clk_i cycles instead.
`default_nettype none
module tsl_link (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic change_n_i,
    input wire logic fast_mode_i,
    input wire logic sleep_i,
    input wire logic burst_active_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic [2:0] wait_kind_i,
    input wire logic wait_load_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic tx_taken_o,
    output logic busy_o,
    output logic awake_o,
    output logic spread_en_o,
    output logic lead_err_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_q, s2_q;
    logic ch1_q, ch2_q;
    logic sck_prev_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            ch1_q <= 1'b1;
            ch2_q <= 1'b1;
            sck_prev_q <= 1'b1;
        end else begin
            s1_q <= {sck_i, ss_n_i, mosi_i};
            s2_q <= s1_q;
            ch1_q <= change_n_i;
            ch2_q <= ch1_q;
            sck_prev_q <= s2_q[2];
        end
    end
    logic sck_s, ss_s, mosi_s;
    assign sck_s = s2_q[2];
    assign ss_s = s2_q[1];
    assign mosi_s = s2_q[0];
    logic sck_fall, sck_rise;
    assign sck_fall = sck_prev_q & ~sck_s;
    assign sck_rise = ~sck_prev_q & sck_s;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    tsl_pkg::tsl_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, rx_q, rx_d;
    logic [2:0] bit_q, bit_d;
    logic miso_q, miso_d, oe_q, oe_d, rxv_q, rxv_d, tk_q, tk_d;
    logic [4:0] lead_q, lead_d;
    logic lerr_q, lerr_d, awake_q, awake_d, wake_ld;
    logic [tsl_pkg::BUSY_W-1:0] wait_cnt;
    logic tmr_load, busy_w;
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        tx_d = tx_q;
        rx_d = rx_q;
        bit_d = bit_q;
        miso_d = miso_q;
        oe_d = ~ss_s;
        rxv_d = 1'b0;
        tk_d = 1'b0;
        lerr_d = lerr_q;
        lead_d = lead_q;
        awake_d = awake_q;
        wake_ld = 1'b0;
        // Wake on either line low, then hold off for the wake gap
        if (!awake_q && (!ss_s || !ch2_q)) begin
            awake_d = 1'b1;
            wake_ld = 1'b1;
        end else if (sleep_i && ss_s) begin
            awake_d = 1'b0;
        end
        if (ss_s) begin
            lead_d = '0;
        end else if (lead_q != 5'h1f) begin
            lead_d = lead_q + 5'h01;
        end
        case (st_q)
            tsl_pkg::TSL_IDLE: begin
                if (!ss_s) begin
                    tx_d = tx_byte_i;
                    tk_d = 1'b1;
                    bit_d = '0;
                    lerr_d = 1'b0;
                    st_d = tsl_pkg::TSL_SHIFT;
                end
            end
            tsl_pkg::TSL_SHIFT: begin
                if (ss_s) begin
                    st_d = tsl_pkg::TSL_IDLE;
                end else if (sck_fall) begin
                    // Lead-time check is only a flag; the host owns the timing
                    if (bit_q == 3'h0 && lead_q < 5'(tsl_pkg::SS_LEAD_CYC)) begin
                        lerr_d = 1'b1;
                    end
                    miso_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                end else if (sck_rise) begin
                    sh_d = {sh_q[6:0], mosi_s};
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        rx_d = {sh_q[6:0], mosi_s};
                        rxv_d = 1'b1;
                        st_d = tsl_pkg::TSL_GAP;
                    end
                end
            end
            tsl_pkg::TSL_GAP: begin
                // Next byte is loaded only once the gap timer has expired
                if (!busy_w && !tmr_load) begin
                    if (ss_s) begin
                        st_d = tsl_pkg::TSL_IDLE;
                    end else begin
                        tx_d = tx_byte_i;
                        tk_d = 1'b1;
                        st_d = tsl_pkg::TSL_SHIFT;
                    end
                end
            end
            default: st_d = tsl_pkg::TSL_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= tsl_pkg::TSL_IDLE;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            bit_q <= 3'h0;
            miso_q <= 1'b1;
            oe_q <= 1'b0;
            rxv_q <= 1'b0;
            tk_q <= 1'b0;
            lead_q <= 5'h00;
            lerr_q <= 1'b0;
            awake_q <= 1'b1;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            bit_q <= bit_d;
            miso_q <= miso_d;
            oe_q <= oe_d;
            rxv_q <= rxv_d;
            tk_q <= tk_d;
            lead_q <= lead_d;
            lerr_q <= lerr_d;
            awake_q <= awake_d;
        end
    end

    // ------------------------------------------------------------
    // Gap and command hold-off
    // ------------------------------------------------------------
    function automatic logic [tsl_pkg::BUSY_W-1:0] gap_cycles(input logic [2:0] kind, input logic fast);
        logic [tsl_pkg::BUSY_W-1:0] c;
        c = fast ? tsl_pkg::BUSY_W'(tsl_pkg::GAP_FAST_CYC) : tsl_pkg::BUSY_W'(tsl_pkg::GAP_NORMAL_CYC);
        case (kind)
            tsl_pkg::WAIT_RESET: c = tsl_pkg::BUSY_W'(tsl_pkg::RESET_WAIT_CYC);
            tsl_pkg::WAIT_STORE: c = tsl_pkg::BUSY_W'(tsl_pkg::STORE_WAIT_CYC);
            tsl_pkg::WAIT_RESTORE: c = tsl_pkg::BUSY_W'(tsl_pkg::RESTORE_WAIT_CYC);
            tsl_pkg::WAIT_ERASE: c = tsl_pkg::BUSY_W'(tsl_pkg::ERASE_WAIT_CYC);
            tsl_pkg::WAIT_TO_NORMAL: c = tsl_pkg::BUSY_W'(tsl_pkg::GAP_NORMAL_CYC);
            default: c = c;
        endcase
        return c;
    endfunction
    // Byte end (incl. last setup byte) starts gap; commands may extend it
    assign tmr_load = rxv_q | wait_load_i | wake_ld;
    assign wait_cnt = wake_ld ? tsl_pkg::BUSY_W'(tsl_pkg::WAKE_GAP_CYC)
                              : gap_cycles(wait_load_i ? wait_kind_i : tsl_pkg::WAIT_NONE, fast_mode_i);
    tsl_busy_timer #(
        .W(tsl_pkg::BUSY_W)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .count_i(wait_cnt),
        .busy_o(busy_w)
    );
    logic busy_q, spr_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            spr_q <= 1'b0;
        end else begin
            busy_q <= busy_w | tmr_load;
            spr_q <= burst_active_i;
        end
    end
    assign miso_o = miso_q;
    assign miso_oe_o = oe_q;
    assign rx_byte_o = rx_q;
    assign rx_valid_o = rxv_q;
    assign tx_taken_o = tk_q;
    assign busy_o = busy_q;
    assign awake_o = awake_q;
    assign spread_en_o = spr_q;
    assign lead_err_o = lerr_q;
endmodule
`default_nettype wire

/* File: verification/tsl_link_monitor.sv */
// Port checker for the touch sensor serial link.
// Bound into tsl_link; watches its ports only.
`default_nettype none
module tsl_link_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ss_n_i,
    input wire logic change_n_i,
    input wire logic fast_mode_i,
    input wire logic burst_active_i,
    input wire logic [2:0] wait_kind_i,
    input wire logic wait_load_i,
    input wire logic miso_oe_o,
    input wire logic rx_valid_o,
    input wire logic tx_taken_o,
    input wire logic busy_o,
    input wire logic awake_o,
    input wire logic spread_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Saturating length of the current busy run; long waits must not wrap
    logic [12:0] run_q;
    logic [12:0] run_d;
    always_comb run_d = (rst_i || !busy_o) ? 13'h0 : run_q + {12'h0, ~&run_q};
    always_ff @(posedge sys_clk_i) run_q <= run_d;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    spread_follow_a: assert property (!$past(rst_i) |-> spread_en_o == $past(burst_active_i))
        else $error("spread enable does not follow the burst flag");
    byte_gap_a: assert property (rx_valid_o |=> busy_o)
        else $error("no gap after a received byte");
    gap_normal_a: assert property ($fell(busy_o) && !fast_mode_i |-> run_q + 1 >= tsl_pkg::GAP_NORMAL_CYC)
        else $error("normal gap too short");
    gap_fast_a: assert property ($fell(busy_o) && fast_mode_i |-> run_q + 1 >= tsl_pkg::GAP_FAST_CYC)
        else $error("fast gap too short");
    valid_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("receive strobe longer than one cycle");
    load_idle_a: assert property (tx_taken_o |-> !busy_o)
        else $error("byte loaded during a gap");
    miso_release_a: assert property ($rose(ss_n_i) |-> ##[1:5] !miso_oe_o)
        else $error("data line still driven after deselect");
    wake_on_low_a: assert property (!awake_o && !(ss_n_i && change_n_i) |-> ##[1:5] awake_o)
        else $error("no wake on select or change low");
    wake_hold_a: assert property ($rose(awake_o) |-> ##[0:2] busy_o)
        else $error("no hold-off after wake");
    hold_load_a: assert property (wait_load_i && wait_kind_i != tsl_pkg::WAIT_NONE |-> ##[1:2] busy_o)
        else $error("command wait not started");
endmodule
bind tsl_link tsl_link_monitor i_mon (.sys_clk_i, .rst_i, .ss_n_i, .change_n_i, .fast_mode_i,
    .burst_active_i, .wait_kind_i, .wait_load_i, .miso_oe_o, .rx_valid_o, .tx_taken_o, .busy_o,
    .awake_o, .spread_en_o);
`default_nettype wire

/* File: verification/tsl_host_model.sv */
// Host master model driving the link pins in real time.
// Callers start frames on a falling system clock edge.
`default_nettype none
module tsl_host_model (
    input wire logic miso_i,
    output logic sck_o,
    output logic ss_n_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Link clock half period; the bench runs faster than the host ceiling to keep runs short,
    // so a real host must stretch each phase to at least 333 ns
    localparam int HALF_NS = 160;
    initial sck_o = 1'b1;
    initial ss_n_o = 1'b1;
    initial mosi_o = 1'b0;
    // Lead is an argument so a host that breaks the select lead can be modelled
    task automatic frame(input logic [7:0] b, input int lead, output logic [7:0] rx);
        ss_n_o = 1'b0;
        #(lead);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            mosi_o = b[i];
            #(HALF_NS);
            sck_o = 1'b1;
            rx[i] = miso_i;
            #(HALF_NS);
        end
        ss_n_o = 1'b1;
        // Released line shows no stale bit
        mosi_o = ~mosi_o;
    endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for tsl_link against a behavioural host and byte queue.
// Assumes the host model and the bound port checker.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, change_n_i = 1'b1, fast_mode_i = 1'b0, sleep_i = 1'b0;
    logic burst_active_i = 1'b0, wait_load_i = 1'b0, rst_p = 1'b1, brst_p = 1'b0;
    logic [7:0] tx_byte_i = 8'h0;
    logic [2:0] wait_kind_i = 3'h0;
    logic [7:0] rx_byte_o;
    logic sck, ss_n, mosi, miso_o, miso_oe_o, rx_valid_o, tx_taken_o, busy_o, awake_o, spread_en_o, lead_err_o;
    logic [7:0] exp_rx[$];
    int err_count = 0, n_compared = 0, n, seed = 65;
    int n_xfer = 0, n_taken = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    tsl_host_model i_host (.miso_i(miso_o), .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi));
    tsl_link i_dut (.sys_clk_i, .rst_i, .sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi), .change_n_i,
        .fast_mode_i, .sleep_i, .burst_active_i, .tx_byte_i, .wait_kind_i, .wait_load_i, .miso_o,
        .miso_oe_o, .rx_byte_o, .rx_valid_o, .tx_taken_o, .busy_o, .awake_o, .spread_en_o, .lead_err_o);
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, output int cnt);
        cnt = 0;
        while (busy_o !== lvl) begin
            @(negedge sys_clk_i);
            cnt++;
            if (cnt > 8000) begin
                err_count++;
                wrap_up();
            end
        end
    endtask
    task automatic do_reset;
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic xfer(input int lead, input logic lerr);
        logic [7:0] b, hb, got;
        int cnt;
        b = 8'($random(seed));
        hb = 8'($random(seed));
        n_xfer++;
        @(posedge sys_clk_i);
        tx_byte_i <= b;
        exp_rx.push_back(hb);
        @(negedge sys_clk_i);
        i_host.frame(hb, lead, got);
        check("miso byte", got, b);
        wait_busy(1'b1, cnt);
        check("lead flag", lead_err_o, lerr);
        // Host holds off the whole gap after every byte, the last setup byte included
        wait_busy(1'b0, cnt);
        check("gap", cnt + 1 >= (fast_mode_i ? tsl_pkg::GAP_FAST_CYC : tsl_pkg::GAP_NORMAL_CYC), 1);
        check("oe released", miso_oe_o, 0);
    endtask
    // Reference model: queued host bytes and the delayed burst flag
    always @(posedge sys_clk_i) begin
        if (!rst_i && !rst_p) check("spread", spread_en_o, brst_p);
        if (rx_valid_o === 1'b1 && exp_rx.size() == 0) check("extra byte", 1, 0);
        else if (rx_valid_o === 1'b1) check("rx byte", rx_byte_o, exp_rx.pop_front());
        if (tx_taken_o === 1'b1) n_taken++;
        rst_p <= rst_i;
        brst_p <= burst_active_i;
        burst_active_i <= 1'($random(seed));
    end
    initial begin
        do_reset();
        @(negedge sys_clk_i);
        check("awake rst", awake_o, 1);
        check("busy rst", busy_o, 0);
        check("miso rst", miso_o, 1);
        repeat (3) xfer(1040, 1'b0);
        @(posedge sys_clk_i);
        fast_mode_i <= 1'b1;
        xfer(1040, 1'b0);
        @(posedge sys_clk_i);
        fast_mode_i <= 1'b0;
        xfer(400, 1'b1);
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk_i);
            wait_kind_i <= 3'(k);
            wait_load_i <= 1'b1;
            @(posedge sys_clk_i);
            wait_load_i <= 1'b0;
            repeat (3) @(negedge sys_clk_i);
            // Every command holds off at least the default gap between transactions
            check("hold busy", busy_o, 1);
            if (k == 5) begin
                wait_busy(1'b0, n);
                check("normal return", n + 4 >= tsl_pkg::GAP_NORMAL_CYC, 1);
            end else begin
                do_reset();
            end
        end
        @(posedge sys_clk_i);
        sleep_i <= 1'b1;
        repeat (6) @(negedge sys_clk_i);
        check("asleep", awake_o, 0);
        @(posedge sys_clk_i);
        sleep_i <= 1'b0;
        change_n_i <= 1'b0;
        repeat (6) @(negedge sys_clk_i);
        check("awake", awake_o, 1);
        check("wake hold", busy_o, 1);
        @(posedge sys_clk_i);
        change_n_i <= 1'b1;
        wait_busy(1'b0, n);
        xfer(1040, 1'b0);
        check("rx left", 8'(exp_rx.size()), 0);
        check("bytes taken", 8'(n_taken), 8'(n_xfer));
        wrap_up();
    end
endmodule
`default_nettype wire
